// *** verilog/obp_regs.vh ***
// constants for the one-bit processor core
`ifndef OBP_REGS_VH
`define OBP_REGS_VH
// opcodes
`define OBP_OP_NOP_ZERO 4'h0
`define OBP_OP_LOAD_BIT 4'h1
`define OBP_OP_LOAD_INV 4'h2
`define OBP_OP_AND 4'h3
`define OBP_OP_AND_INV 4'h4
`define OBP_OP_OR 4'h5
`define OBP_OP_OR_INV 4'h6
`define OBP_OP_XNOR 4'h7
`define OBP_OP_STORE_BIT 4'h8
`define OBP_OP_STORE_INV 4'h9
`define OBP_OP_IN_GATE 4'hA
`define OBP_OP_OUT_GATE 4'hB
`define OBP_OP_JUMP 4'hC
`define OBP_OP_RETURN 4'hD
`define OBP_OP_SKIP_ZERO 4'hE
`define OBP_OP_NOP_ONES 4'hF
// register addresses (byte)
`define OBP_ADDR_CTRL 32'h0000_0000
`define OBP_ADDR_STATUS 32'h0000_0004
`define OBP_ADDR_DIVIDE 32'h0000_0008
// ctrl field positions
`define OBP_CTRL_MASTER_RESET 0
`define OBP_CTRL_EXT_CLOCK 1
// reset values
`define OBP_CTRL_RESET 2'h1
`define OBP_DIVIDE_RESET 8'h0C
// oscillator restart delay: 2000 ns, 50 sys_clk cycles of 40 ns, sized for the hold counter
`define OBP_RESTART_NS 2000
`define OBP_CLK_NS 40
`define OBP_RESTART_CYCLES 16'h0032
// axi answers
`define OBP_RESP_OKAY 2'h0
`define OBP_RESP_SLVERR 2'h2
`endif

// *** verilog/obp_sync.v ***
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
module obp_sync
(
  // clock and reset
  input wire sys_clk,
  input wire reset_n,
  // level in and out
  input wire din,
  output reg dout
);
  reg stage1;

  // first stage is read only by the second
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1 <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule // obp_sync

// *** verilog/obp_osc.v ***
// machine clock generator: divider from sys_clk or external clock input
`timescale 1ns/1ps
`include "obp_regs.vh"
module obp_osc
(
  // clock and reset
  input wire sys_clk,
  input wire reset_n,
  // control
  input wire master_reset,
  input wire use_ext_clock,
  input wire ext_clock_sync,
  input wire [7:0] half_period,
  // machine clock level and edge pulses
  output reg clock_out_pin,
  output reg rise_pulse,
  output reg fall_pulse
);
  reg [7:0] div_count;
  reg [15:0] hold_count;
  reg next_level;

  // pick the next clock level from divider or external input
  always @*
  begin
    next_level = clock_out_pin;
    if (master_reset || hold_count != 16'h0000)
      next_level = 1'b1;
    else if (use_ext_clock)
      next_level = ext_clock_sync;
    else if (div_count >= half_period)
      next_level = ~clock_out_pin;
  end

  // divider, restart delay and edge detection
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_count <= 8'h00;
      hold_count <= 16'h0000;
      clock_out_pin <= 1'b1;
      rise_pulse <= 1'b0;
      fall_pulse <= 1'b0;
    end
    else
    begin
      if (master_reset)
        hold_count <= `OBP_RESTART_CYCLES;
      else if (hold_count != 16'h0000)
        hold_count <= hold_count - 16'h0001;
      if (master_reset || div_count >= half_period || hold_count != 16'h0000)
        div_count <= 8'h00;
      else
        div_count <= div_count + 8'h01;
      clock_out_pin <= next_level;
      rise_pulse <= ~clock_out_pin & next_level;
      fall_pulse <= clock_out_pin & ~next_level;
    end
  end
endmodule // obp_osc

// *** verilog/obp_core.v ***
// one-bit logic processor core with axi4-lite control registers
// What this block does
// - opcode 0000 pulses zero flag, no change
// - opcode 1111 pulses ones flag, no change
// - 0001 loads data into result
// - 0010 loads inverted data into result
// - 0011 ands data into result
// - 0100 ands inverted data into result
// - 0101 ors data into result
// - 0110 ors inverted data into result
// - 0111 result set when equal to data
// - 1000 drives result out with write strobe
// - 1001 drives inverted result with write strobe
// - 1010 loads data into input gate
// - 1011 loads data into output gate
// - 1100 pulses jump strobe only
// - 1101 pulses return, skips next instruction
// - 1110 skips next when result zero
// - clock from oscillator divider or external pin, shown on clock output
// - data reaches logic unit only when gated
// - write strobe only while output gate high
// - master reset clears registers and flags
// - clock held high in reset, delayed restart
// - result shown on dedicated output
// - opcode latched on falling clock edge
// - every instruction takes one clock period
// - flags held one full clock period
`timescale 1ns/1ps
`include "obp_regs.vh"
module obp_core
(
  // clock and reset
  input wire sys_clk,
  input wire reset_n,
  // axi4-lite write address
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // program memory opcode pins
  input wire [3:0] opcode_pins,
  // external clock pin
  input wire ext_clock_pin,
  // bidirectional data line
  input wire data_in,
  output reg data_out,
  output reg data_oe,
  // strobes and flags
  output reg write_strobe,
  output reg jump_strobe,
  output reg return_strobe,
  output reg flag_zero_pulse,
  output reg flag_ones_pulse,
  // machine clock and result
  output wire clock_out_pin,
  output reg result_pin
);
  // control registers
  reg [1:0] ctrl;
  reg [7:0] half_period;
  // processor state
  reg result_bit;
  reg input_gate;
  reg output_gate;
  reg skip_next;
  reg [3:0] opcode_latch;
  // synchronised pins
  wire [3:0] opcode_sync;
  wire data_sync;
  wire ext_sync;
  wire rise_pulse;
  wire fall_pulse;
  wire master_reset;
  // axi holding state
  reg aw_held;
  reg w_held;
  reg [31:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  // next values
  reg next_result;
  reg next_input_gate;
  reg next_output_gate;
  reg next_skip;
  reg next_drive;
  reg next_write;
  reg next_data;
  reg gated_data;
  reg do_exec;

  assign master_reset = ctrl[`OBP_CTRL_MASTER_RESET];

  // every pin passes two flip-flops before the logic sees it
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1)
    begin : g_sync
      wire pin_in;
      wire pin_out;
      if (gi < 4)
      begin : g_op
        assign pin_in = opcode_pins[gi];
        assign opcode_sync[gi] = pin_out;
      end
      else if (gi == 4)
      begin : g_dat
        assign pin_in = data_in;
        assign data_sync = pin_out;
      end
      else
      begin : g_ext
        assign pin_in = ext_clock_pin;
        assign ext_sync = pin_out;
      end
      obp_sync u_sync
      (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .din(pin_in),
        .dout(pin_out)
      );
    end
  endgenerate

  // machine clock generator
  obp_osc u_osc
  (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .master_reset(master_reset),
    .use_ext_clock(ctrl[`OBP_CTRL_EXT_CLOCK]),
    .ext_clock_sync(ext_sync),
    .half_period(half_period),
    .clock_out_pin(clock_out_pin),
    .rise_pulse(rise_pulse),
    .fall_pulse(fall_pulse)
  );

  // decode and logic unit for the latched opcode
  always @*
  begin
    do_exec = ~skip_next;
    gated_data = data_sync & input_gate;
    next_result = result_bit;
    next_input_gate = input_gate;
    next_output_gate = output_gate;
    next_skip = 1'b0;
    next_drive = 1'b0;
    next_write = 1'b0;
    next_data = 1'b0;
    if (do_exec)
    begin
      case (opcode_latch)
        `OBP_OP_LOAD_BIT: next_result = gated_data;
        `OBP_OP_LOAD_INV: next_result = ~gated_data;
        `OBP_OP_AND: next_result = result_bit & gated_data;
        `OBP_OP_AND_INV: next_result = result_bit & ~gated_data;
        `OBP_OP_OR: next_result = result_bit | gated_data;
        `OBP_OP_OR_INV: next_result = result_bit | ~gated_data;
        `OBP_OP_XNOR: next_result = ~(result_bit ^ gated_data);
        `OBP_OP_STORE_BIT:
        begin
          next_drive = output_gate;
          next_write = output_gate;
          next_data = result_bit;
        end
        `OBP_OP_STORE_INV:
        begin
          next_drive = output_gate;
          next_write = output_gate;
          next_data = ~result_bit;
        end
        `OBP_OP_IN_GATE: next_input_gate = data_sync;
        `OBP_OP_OUT_GATE: next_output_gate = data_sync;
        `OBP_OP_RETURN: next_skip = 1'b1;
        `OBP_OP_SKIP_ZERO: next_skip = ~result_bit;
        default: next_result = result_bit;
      endcase
    end
  end

  // opcode latch, state update and outputs on machine clock falls; result pin follows every sys_clk
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      opcode_latch <= 4'h0;
      result_bit <= 1'b0;
      input_gate <= 1'b0;
      output_gate <= 1'b0;
      skip_next <= 1'b0;
      data_out <= 1'b0;
      data_oe <= 1'b0;
      write_strobe <= 1'b0;
      jump_strobe <= 1'b0;
      return_strobe <= 1'b0;
      flag_zero_pulse <= 1'b0;
      flag_ones_pulse <= 1'b0;
      result_pin <= 1'b0;
    end
    else if (master_reset)
    begin
      opcode_latch <= 4'h0;
      result_bit <= 1'b0;
      input_gate <= 1'b0;
      output_gate <= 1'b0;
      skip_next <= 1'b0;
      data_out <= 1'b0;
      data_oe <= 1'b0;
      write_strobe <= 1'b0;
      jump_strobe <= 1'b0;
      return_strobe <= 1'b0;
      flag_zero_pulse <= 1'b0;
      flag_ones_pulse <= 1'b0;
      result_pin <= 1'b0;
    end
    else
    begin
      result_pin <= result_bit;
      if (fall_pulse)
      begin
        // one instruction per period: execute previous, latch the new one
        opcode_latch <= opcode_sync;
        result_bit <= next_result;
        input_gate <= next_input_gate;
        output_gate <= next_output_gate;
        skip_next <= next_skip;
        data_out <= next_data;
        data_oe <= next_drive;
        write_strobe <= next_write;
        jump_strobe <= do_exec && opcode_latch == `OBP_OP_JUMP;
        return_strobe <= do_exec && opcode_latch == `OBP_OP_RETURN;
        flag_zero_pulse <= do_exec && opcode_latch == `OBP_OP_NOP_ZERO;
        flag_ones_pulse <= do_exec && opcode_latch == `OBP_OP_NOP_ONES;
      end
    end
  end

  // axi4-lite write side: address and data taken in either order
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      ctrl <= `OBP_CTRL_RESET;
      half_period <= `OBP_DIVIDE_RESET;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held && !s_axi_bvalid)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `OBP_RESP_OKAY;
        if ({aw_addr[31:2], 2'h0} == `OBP_ADDR_CTRL)
        begin
          if (w_strb[0])
            ctrl <= w_data[1:0];
        end
        else if ({aw_addr[31:2], 2'h0} == `OBP_ADDR_DIVIDE)
        begin
          if (w_strb[0])
            half_period <= w_data[7:0];
        end
        else if ({aw_addr[31:2], 2'h0} != `OBP_ADDR_STATUS)
          s_axi_bresp <= `OBP_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // axi4-lite read side
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `OBP_RESP_OKAY;
      if ({s_axi_araddr[31:2], 2'h0} == `OBP_ADDR_CTRL)
        s_axi_rdata <= {30'h0, ctrl};
      else if ({s_axi_araddr[31:2], 2'h0} == `OBP_ADDR_STATUS)
        s_axi_rdata <= {24'h0, opcode_latch, skip_next, output_gate, input_gate,
          result_bit};
      else if ({s_axi_araddr[31:2], 2'h0} == `OBP_ADDR_DIVIDE)
        s_axi_rdata <= {24'h0, half_period};
      else
      begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `OBP_RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule // obp_core

// *** sim/obp_core_monitor.sv ***
// port checker for the one-bit processor core
`timescale 1ns/1ps
module obp_core_monitor
(
  // clock and reset
  input wire sys_clk,
  input wire reset_n,
  // processor pins
  input wire clock_out_pin,
  input wire data_oe,
  input wire write_strobe,
  input wire jump_strobe,
  input wire return_strobe,
  input wire flag_zero_pulse,
  input wire flag_ones_pulse,
  input wire result_pin
);
  wire any_flag;
  // all decoded pulses together
  assign any_flag = jump_strobe | return_strobe | flag_zero_pulse | flag_ones_pulse | write_strobe;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_strobe_drives: assert property (write_strobe |-> data_oe)
    else $error("write strobe without data drive");
  // pulses move one sys_clk after the registered fall of the machine clock
  a_flag_at_fall: assert property ($rose(any_flag) |->
    $past(clock_out_pin, 2) && !$past(clock_out_pin, 1))
    else $error("pulse rose away from a machine clock fall");
  a_one_pulse: assert property ($onehot0({jump_strobe, return_strobe, flag_zero_pulse,
    flag_ones_pulse, write_strobe}))
    else $error("two decoded pulses at once");
  a_jump_period: assert property ($rose(jump_strobe) |-> jump_strobe [*8])
    else $error("jump pulse shorter than a machine period");
  a_zero_period: assert property ($rose(flag_zero_pulse) |-> flag_zero_pulse [*8])
    else $error("zero flag shorter than a machine period");
  a_write_period: assert property ($rose(write_strobe) |-> write_strobe [*8])
    else $error("write strobe shorter than a machine period");
  a_drive_at_fall: assert property ($rose(data_oe) |->
    $past(clock_out_pin, 2) && !$past(clock_out_pin, 1))
    else $error("data drive began away from a fall");
  // a master reset also clears the pin, but it raises the machine clock at once
  a_result_timing: assert property ($changed(result_pin) && !clock_out_pin |->
    $past(clock_out_pin, 3) && !$past(clock_out_pin, 2))
    else $error("result pin moved away from a fall");
endmodule // obp_core_monitor

// *** sim/obp_far_end.sv ***
// program memory, input selector and output latch beside the core
`timescale 1ns/1ps
module obp_far_end
(
  // clock
  input wire sys_clk,
  // core side
  input wire clock_out_pin,
  input wire data_out,
  input wire data_oe,
  input wire write_strobe,
  output reg [3:0] opcode_pins,
  output wire data_in,
  // next word from the bench
  input wire [3:0] prog_op,
  input wire prog_bit,
  output reg sel_bit,
  output reg latch_q
);
  reg clk_q;
  initial
  begin
    {opcode_pins, sel_bit, latch_q, clk_q} = 7'h1;
  end
  // new word after each machine clock fall, steady until the next fall
  always @(posedge sys_clk)
  begin
    clk_q <= clock_out_pin;
    if (clk_q && !clock_out_pin)
    begin
      opcode_pins <= prog_op;
      sel_bit <= prog_bit;
    end
    if (write_strobe && data_oe)
      latch_q <= data_out;
  end
  // the core owns the line while enabled, else the selector drives it
  assign data_in = data_oe ? data_out : sel_bit;
endmodule // obp_far_end

// *** sim/tb_one_bit_logic_processor_core.sv ***
// self-checking bench for the one-bit processor core
`timescale 1ns/1ps
`include "obp_regs.vh"
module tb_one_bit_logic_processor_core;
  reg sys_clk, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, lfsr, rd;
  reg [3:0] s_axi_wstrb, prog_op, opq;
  reg [1:0] rs;
  reg prog_bit, hold_ones, running, mclk_q, ext_clk;
  reg res, in_gate, out_gate, skp, e_fz, e_fo, e_j, e_r, e_w, e_oe, e_do, e_lat, d, g;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] opcode_pins;
  wire data_in, data_out, data_oe, write_strobe, jump_strobe, return_strobe;
  wire flag_zero_pulse, flag_ones_pulse, clock_out_pin, result_pin, sel_bit, latch_q;
  integer errors, checks_done, nfall, n;
  obp_core DUT
  (
    .sys_clk(sys_clk), .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .opcode_pins(opcode_pins),
    .ext_clock_pin(ext_clk), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .write_strobe(write_strobe), .jump_strobe(jump_strobe), .return_strobe(return_strobe),
    .flag_zero_pulse(flag_zero_pulse), .flag_ones_pulse(flag_ones_pulse),
    .clock_out_pin(clock_out_pin), .result_pin(result_pin)
  );
  obp_far_end u_far
  (
    .sys_clk(sys_clk), .clock_out_pin(clock_out_pin), .data_out(data_out), .data_oe(data_oe),
    .write_strobe(write_strobe), .opcode_pins(opcode_pins), .data_in(data_in),
    .prog_op(prog_op), .prog_bit(prog_bit), .sel_bit(sel_bit), .latch_q(latch_q)
  );
  // 25 MHz system clock
  always #20 sys_clk = ~sys_clk;
  function [31:0] lfsr_next(input [31:0] v);
    lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task check_val(input [63:0] what, input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
        errors = errors + 1;
        $display("wrong value %0s expected %0h seen %0h", what, exp, seen);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // one write, address and data offered together
  task axi_write(input [31:0] a, input [31:0] dat, output [1:0] r);
    reg aw_ok;
    reg w_ok;
    begin
      @(posedge sys_clk);
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= dat;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
        @(negedge sys_clk);
        aw_ok = aw_ok | (s_axi_awready === 1'b1);
        w_ok = w_ok | (s_axi_wready === 1'b1);
        @(posedge sys_clk);
        if (aw_ok) s_axi_awvalid <= 1'b0;
        if (w_ok) s_axi_wvalid <= 1'b0;
      end
      @(negedge sys_clk);
      while (s_axi_bvalid !== 1'b1)
        @(negedge sys_clk);
      r = s_axi_bresp;
      @(posedge sys_clk);
      s_axi_bready <= 1'b0;
    end
  endtask
  task axi_read(input [31:0] a, output [31:0] dat, output [1:0] r);
    begin
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(negedge sys_clk);
      while (s_axi_arready !== 1'b1)
        @(negedge sys_clk);
      @(posedge sys_clk);
      s_axi_arvalid <= 1'b0;
      @(negedge sys_clk);
      while (s_axi_rvalid !== 1'b1)
        @(negedge sys_clk);
      dat = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge sys_clk);
      s_axi_rready <= 1'b0;
    end
  endtask
  // execute the word latched at the previous fall
  task step_model;
    begin
      d = e_oe ? e_do : sel_bit;
      g = in_gate & d;
      {e_fz, e_fo, e_j, e_r, e_w, e_oe} = 6'h0;
      if (skp)
        skp = 1'b0;
      else if (nfall > 0)
        case (opq)
          4'h0: e_fz = 1'b1;
          4'h1: res = g;
          4'h2: res = !g;
          4'h3: res = res & g;
          4'h4: res = res & !g;
          4'h5: res = res | g;
          4'h6: res = res | !g;
          4'h7: res = (res == g);
          4'h8, 4'h9:
            if (out_gate)
            begin
              {e_w, e_oe} = 2'h3;
              e_do = res ^ opq[0];
              e_lat = e_do;
            end
          4'hA: in_gate = d;
          4'hB: out_gate = d;
          4'hC: e_j = 1'b1;
          4'hD: {e_r, skp} = 2'h3;
          4'hE: skp = !res;
          default: e_fo = 1'b1;
        endcase
      opq = opcode_pins;
      nfall = nfall + 1;
    end
  endtask
  // model at each machine fall, compare pins at each rise
  always @(posedge sys_clk)
  begin
    if (running && mclk_q && !clock_out_pin)
    begin
      step_model;
      lfsr = lfsr_next(lfsr);
      prog_op <= hold_ones ? 4'hF : lfsr[3:0];
      prog_bit <= lfsr[9];
    end
    if (running && !mclk_q && clock_out_pin && nfall > 1)
    begin
      check_val("flag0", flag_zero_pulse, e_fz);
      check_val("flagf", flag_ones_pulse, e_fo);
      check_val("jump", jump_strobe, e_j);
      check_val("return", return_strobe, e_r);
      check_val("write", write_strobe, e_w);
      check_val("oe", data_oe, e_oe);
      check_val("dout", data_out & e_oe, e_do & e_oe);
      check_val("result", result_pin, res);
      check_val("latch", latch_q, e_lat);
    end
    mclk_q <= clock_out_pin;
  end
  initial
  begin
    {sys_clk, reset_n, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 98'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_wstrb, prog_op, prog_bit, hold_ones, running, mclk_q} = 12'hF00;
    {res, in_gate, out_gate, skp, e_fz, e_fo, e_j, e_r, e_w, e_oe, e_do, e_lat} = 12'h0;
    {errors, checks_done, nfall} = 96'h0;
    opq = 4'h0;
    ext_clk = 1'b1;
    lfsr = 32'hD2DA4C4B;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    // reset values, held machine clock, unmapped and read-only places
    axi_read(`OBP_ADDR_CTRL, rd, rs);
    check_val("ctrl", rd, 32'h1);
    check_val("clkhold", clock_out_pin, 1);
    check_val("flags", {jump_strobe, return_strobe, flag_zero_pulse, flag_ones_pulse}, 0);
    axi_read(`OBP_ADDR_DIVIDE, rd, rs);
    check_val("divide", rd, 32'hC);
    axi_read(32'h0000_000C, rd, rs);
    check_val("resp", rs, `OBP_RESP_SLVERR);
    axi_write(`OBP_ADDR_STATUS, 32'hFF, rs);
    check_val("resp", rs, `OBP_RESP_OKAY);
    axi_write(`OBP_ADDR_DIVIDE, 32'h3, rs);
    axi_read(`OBP_ADDR_DIVIDE, rd, rs);
    check_val("divide", rd, 32'h3);
    $display("test registers done");
    // leave master reset: clock must stay high through the restart delay
    running = 1'b1;
    axi_write(`OBP_ADDR_CTRL, 32'h0, rs);
    n = 0;
    while (clock_out_pin === 1'b1 && n < 200)
    begin
      @(negedge sys_clk);
      n = n + 1;
    end
    check_val("restart", n >= 45 && n <= 60, 1);
    $display("test restart done");
    // random program, then a run of no-ops to read a quiet status
    repeat (3200) @(posedge sys_clk);
    hold_ones <= 1'b1;
    repeat (48) @(posedge sys_clk);
    $display("test program done");
    axi_read(`OBP_ADDR_STATUS, rd, rs);
    check_val("status", rd[7:0], {4'hF, 1'b0, out_gate, in_gate, res});
    $display("test status done");
    // external clock: the machine clock follows the pin through its synchroniser
    axi_write(`OBP_ADDR_CTRL, 32'h2, rs);
    repeat (40)
    begin
      ext_clk <= ~ext_clk;
      repeat (6) @(posedge sys_clk);
      check_val("extclk", clock_out_pin, ext_clk);
    end
    $display("test external clock done");
    // master reset in mid-run: state and flags cleared, machine clock held high
    running = 1'b0;
    axi_write(`OBP_ADDR_CTRL, 32'h1, rs);
    repeat (2) @(posedge sys_clk);
    check_val("clkhold", clock_out_pin, 1);
    check_val("mrflags", {jump_strobe, return_strobe, flag_zero_pulse, flag_ones_pulse}, 0);
    check_val("mrresult", result_pin, 0);
    axi_read(`OBP_ADDR_STATUS, rd, rs);
    check_val("mrstatus", rd, 32'h0);
    $display("test master reset done");
    final_report;
  end
  // cut a hang short; the run needs under 4000 cycles
  initial
  begin
    #400000;
    errors = errors + 1;
    final_report;
  end
endmodule // tb_one_bit_logic_processor_core
// attach the port checker to the core
bind obp_core obp_core_monitor u_mon
(
  .sys_clk(sys_clk), .reset_n(reset_n), .clock_out_pin(clock_out_pin), .data_oe(data_oe),
  .write_strobe(write_strobe), .jump_strobe(jump_strobe), .return_strobe(return_strobe),
  .flag_zero_pulse(flag_zero_pulse), .flag_ones_pulse(flag_ones_pulse),
  .result_pin(result_pin)
);
